// ===== rtl/twp_pkg.sv
package twp_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_OPTION = 8'h00;
  localparam logic [7:0] OFS_COUNT  = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CMD    = 8'h0C;

  // option register fields
  localparam int OPT_WDT_EN_BIT = 6;
  localparam int OPT_SRC_BIT    = 5;
  localparam int OPT_EDGE_BIT   = 4;
  localparam int OPT_PRESCALER_ASSIGN_BIT_BIT   = 3;
  localparam int OPT_RATE_LSB   = 0;
  localparam int OPT_RATE_W     = 3;
  localparam logic [7:0] OPT_RST = 8'hBF;

  // status fields
  localparam int STAT_PD_BIT = 3;
  localparam int STAT_TO_BIT = 4;

  // command register bits
  localparam int CMD_CLRWDT_BIT = 0;
  localparam int CMD_POWER_DOWN_INSTRUCTION_BIT  = 1;

  // clock ratios and counter widths
  localparam int CNT_DIV  = 4;
  localparam int WDT_DIV  = 16;
  localparam int WDT_BITS = 15;
  localparam int PRE_BITS = 8;

endpackage : twp_pkg

// ===== rtl/twp_presc_if.sv
`timescale 1ns/1ps
interface twp_presc_if;
  logic       tick_in;
  logic       clr;
  logic [2:0] rate;
  logic       wdt_mode;
  logic       tick_out;

  modport owner (output tick_in, output clr, output rate,
                 output wdt_mode, input tick_out);
  modport presc (input tick_in, input clr, input rate,
                 input wdt_mode, output tick_out);
endinterface : twp_presc_if

// ===== rtl/twp_prescaler.sv
`timescale 1ns/1ps
module twp_prescaler
  import twp_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_sync_b,
  // shared prescaler port
  twp_presc_if.presc pif
);

  logic [PRE_BITS-1:0] cnt_ff;
  logic [PRE_BITS-1:0] nxt_cnt;
  logic [PRE_BITS:0]   span;
  logic [PRE_BITS-1:0] mask;

  // watchdog divides by 2^n, timer by 2^(n+1)
  always_comb
  begin
    span = (pif.wdt_mode) ? ((PRE_BITS+1)'(1) << pif.rate)
                          : ((PRE_BITS+1)'(2) << pif.rate);
    mask = span[PRE_BITS-1:0] - 8'h01;
    pif.tick_out = pif.tick_in && ((cnt_ff & mask) == mask);
    nxt_cnt = cnt_ff;
    if (pif.clr)
      nxt_cnt = '0;
    else if (pif.tick_in)
      nxt_cnt = cnt_ff + 8'h01;
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;
  end

  a_presc_clear: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    pif.clr |=> cnt_ff == 8'h00)
    else $error("prescaler not cleared");

endmodule : twp_prescaler

// ===== rtl/twp_top.sv
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
// Overview of operation
// - count register steps on source or prescaler
// - source is clock divided four or pin
// - watchdog is 15-bit counter at clock/16
// - watchdog expiry resets the microcontroller
// - prescaler may lengthen watchdog up to 128
// - reset and clear command zero watchdog
// - those also clear prescaler when watchdog-assigned
// - option register is write-only, full writes
// - option bit 6 enables the watchdog
// - power-down flag bit 3, timeout bit 4
// - bit 3 assigns prescaler, bits 2:0 rate
// - external count edge rising or falling
// - bit 5 source select, bit 4 edge
// - timer rate code 011 divides by sixteen
// - reset sets option ones except enable bit
module twp_top
  import twp_pkg::*;
#(
  // watchdog length; a quick bench may shorten it
  parameter int WDT_W = WDT_BITS
)
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // count pin
  input  wire logic        external_count_input,
  // to the core
  output logic             wdt_reset,
  output logic             power_down_flag,
  output logic             timeout_flag
);

  localparam logic [1:0] DIV4_LAST  = 2'(CNT_DIV - 1);
  localparam logic [3:0] DIV16_LAST = 4'(WDT_DIV - 1);

  twp_presc_if pif ();

  // reset release through two flops
  logic rst_meta_ff;
  logic rst_sync_b;
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_b  <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_b  <= rst_meta_ff;
    end
  end

  // state
  logic [7:0]          opt_ff,    nxt_opt;
  logic [7:0]          count_ff,  nxt_count;
  logic [WDT_W-1:0]    wdt_ff,    nxt_wdt;
  logic [1:0]          div4_ff,   nxt_div4;
  logic [3:0]          div16_ff,  nxt_div16;
  logic                pin_ff,    nxt_pin;
  logic                pd_ff,     nxt_pd;
  logic                to_ff,     nxt_to;
  logic                wrst_ff,   nxt_wrst;
  logic [31:0]         rdata_ff,  nxt_rdata;
  logic                rdy_ff,    nxt_rdy;
  logic                err_ff,    nxt_err;

  // decode
  logic acc, wr, rd, hit_opt, hit_cnt, hit_stat, hit_cmd, mapped;
  logic cmd_clr, cmd_pd, tick4, tick16, edge_seen, src_evt;
  logic wdt_en, prescaler_assign_bit, wdt_ovf, wdt_tmo, presc_clr;

  always_comb
  begin
    acc      = psel && penable && rdy_ff;
    wr       = acc && pwrite;
    rd       = acc && !pwrite;
    hit_opt  = (paddr == OFS_OPTION);
    hit_cnt  = (paddr == OFS_COUNT);
    hit_stat = (paddr == OFS_STATUS);
    hit_cmd  = (paddr == OFS_CMD);
    mapped   = hit_opt || hit_cnt || hit_stat || hit_cmd;
    cmd_clr  = wr && hit_cmd && pwdata[CMD_CLRWDT_BIT];
    cmd_pd   = wr && hit_cmd && pwdata[CMD_POWER_DOWN_INSTRUCTION_BIT];
    wdt_en   = opt_ff[OPT_WDT_EN_BIT];
    prescaler_assign_bit     = opt_ff[OPT_PRESCALER_ASSIGN_BIT_BIT];
    tick4    = (div4_ff == DIV4_LAST);
    tick16   = (div16_ff == DIV16_LAST);
    // pin is already synchronous; edge taken against last sample
    edge_seen = opt_ff[OPT_EDGE_BIT]
              ? (external_count_input && !pin_ff)
              : (!external_count_input && pin_ff);
    src_evt  = opt_ff[OPT_SRC_BIT] ? edge_seen : tick4;
    wdt_ovf  = wdt_en && tick16 && (&wdt_ff);
    wdt_tmo  = prescaler_assign_bit ? pif.tick_out : wdt_ovf;
    presc_clr = prescaler_assign_bit && (cmd_clr || cmd_pd || wdt_tmo);
  end

  // prescaler hookup
  assign pif.tick_in  = prescaler_assign_bit ? wdt_ovf : src_evt;
  assign pif.clr      = presc_clr;
  assign pif.rate     = opt_ff[OPT_RATE_LSB +: OPT_RATE_W];
  assign pif.wdt_mode = prescaler_assign_bit;

  twp_prescaler u_presc (
    .clk_sys    (clk_sys),
    .rst_sync_b (rst_sync_b),
    .pif        (pif)
  );

  // counters, option register, flags
  always_comb
  begin
    nxt_div4  = div4_ff + 2'h1;
    nxt_div16 = div16_ff + 4'h1;
    nxt_pin   = external_count_input;
    nxt_opt   = opt_ff;
    nxt_count = count_ff;
    nxt_wdt   = wdt_ff;
    nxt_pd    = pd_ff;
    nxt_to    = to_ff;
    nxt_wrst  = 1'b0;
    if (!prescaler_assign_bit ? pif.tick_out : src_evt)
      nxt_count = count_ff + 8'h01;
    if (wr && hit_cnt)
      nxt_count = pwdata[7:0];
    // only a whole-word write or an expiry changes the option register
    if (wr && hit_opt)
      nxt_opt = pwdata[7:0];
    if (wdt_en && tick16)
      nxt_wdt = wdt_ff + WDT_W'(1);
    if (cmd_clr)
    begin
      nxt_wdt = '0;
      nxt_pd  = 1'b1;
      nxt_to  = 1'b1;
    end
    if (cmd_pd)
    begin
      nxt_wdt = '0;
      nxt_pd  = 1'b0;
      nxt_to  = 1'b1;
    end
    // expiry outranks a same-cycle clear so the event is never lost
    if (wdt_tmo)
    begin
      nxt_wrst = 1'b1;
      nxt_wdt  = '0;
      nxt_opt  = OPT_RST;
      nxt_to   = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      opt_ff   <= OPT_RST;
      count_ff <= '0;
      wdt_ff   <= '0;
      div4_ff  <= '0;
      div16_ff <= '0;
      pin_ff   <= 1'b0;
      pd_ff    <= 1'b1;
      to_ff    <= 1'b1;
      wrst_ff  <= 1'b0;
    end
    else
    begin
      opt_ff   <= nxt_opt;
      count_ff <= nxt_count;
      wdt_ff   <= nxt_wdt;
      div4_ff  <= nxt_div4;
      div16_ff <= nxt_div16;
      pin_ff   <= nxt_pin;
      pd_ff    <= nxt_pd;
      to_ff    <= nxt_to;
      wrst_ff  <= nxt_wrst;
    end
  end

  // apb: one wait state, pready raised on the second access cycle
  always_comb
  begin
    nxt_rdy   = psel && penable && !rdy_ff;
    nxt_rdata = '0;
    nxt_err   = 1'b0;
    if (psel && penable && !rdy_ff)
    begin
      nxt_err = !mapped;
      if (!pwrite && hit_cnt)
        nxt_rdata = {24'h000000, count_ff};
      else if (!pwrite && hit_stat)
      begin
        nxt_rdata[STAT_PD_BIT] = pd_ff;
        nxt_rdata[STAT_TO_BIT] = to_ff;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      rdy_ff   <= 1'b0;
      rdata_ff <= '0;
      err_ff   <= 1'b0;
    end
    else
    begin
      rdy_ff   <= nxt_rdy;
      rdata_ff <= nxt_rdata;
      err_ff   <= nxt_err;
    end
  end

  assign prdata          = rdata_ff;
  assign pready          = rdy_ff;
  assign pslverr         = err_ff;
  assign wdt_reset       = wrst_ff;
  assign power_down_flag = pd_ff;
  assign timeout_flag    = to_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_sync_b);

  a_wdt_reset_pulse: assert property (
    wdt_tmo |=> wdt_reset ##1 !wdt_reset)
    else $error("watchdog reset pulse wrong");

  a_timeout_flag: assert property (
    wdt_tmo |=> !timeout_flag && wdt_ff == '0)
    else $error("timeout flag not cleared on expiry");

  a_clear_watchdog: assert property (
    (cmd_clr && !wdt_tmo) |=> wdt_ff == '0 && timeout_flag && power_down_flag)
    else $error("clear command did not clear watchdog");

  a_option_reset: assert property (
    wdt_tmo |=> opt_ff == OPT_RST && !opt_ff[OPT_WDT_EN_BIT])
    else $error("option register not restored");

  a_count_direct: assert property (
    (!prescaler_assign_bit && !(wr && hit_cnt) && !pif.tick_out && !src_evt)
      |=> count_ff == $past(count_ff))
    else $error("count moved without an edge");

  a_count_step: assert property (
    (prescaler_assign_bit && src_evt && !(wr && hit_cnt))
      |=> count_ff == $past(count_ff) + 8'h01)
    else $error("count did not advance");

  a_div4_spacing: assert property (
    tick4 |=> !tick4 [*3] ##1 tick4)
    else $error("divide by four spacing wrong");

  a_div16_spacing: assert property (
    tick16 |-> ##16 tick16)
    else $error("divide by sixteen spacing wrong");

  a_wdt_disabled: assert property (
    !wdt_en |-> !wdt_ovf ##1 !wdt_reset)
    else $error("timeout while watchdog disabled");

  a_option_unread: assert property (
    (rd && hit_opt) |-> prdata == 32'h00000000)
    else $error("option register readable");

  // checks below cover the bus answer, flags and counting paths
  a_pd_command: assert property (
    (cmd_pd && !wdt_tmo)
      |=> !power_down_flag && timeout_flag && wdt_ff == '0)
    else $error("power-down command mishandled");

  a_option_write: assert property (
    (wr && hit_opt && !wdt_tmo) |=> opt_ff == $past(pwdata[7:0]))
    else $error("option write lost");

  a_count_write: assert property (
    (wr && hit_cnt) |=> count_ff == $past(pwdata[7:0]))
    else $error("count write lost");

  a_wdt_step: assert property (
    (wdt_en && tick16 && !cmd_clr && !cmd_pd && !wdt_tmo)
      |=> wdt_ff == $past(wdt_ff) + WDT_W'(1))
    else $error("watchdog did not step");

  a_wdt_quiet: assert property (
    (!(wdt_en && tick16) && !cmd_clr && !cmd_pd && !wdt_tmo)
      |=> wdt_ff == $past(wdt_ff))
    else $error("watchdog moved off its tick");

  a_status_read: assert property (
    (rd && hit_stat)
      |-> prdata[STAT_PD_BIT] == $past(power_down_flag)
          && prdata[STAT_TO_BIT] == $past(timeout_flag))
    else $error("status read disagrees with flags");

  a_flags_hold: assert property (
    (!cmd_clr && !cmd_pd && !wdt_tmo)
      |=> $stable(power_down_flag) && $stable(timeout_flag))
    else $error("flag changed with no cause");

  a_pready_single: assert property (
    pready |=> !pready)
    else $error("pready held too long");

  a_err_with_ready: assert property (
    pslverr |-> pready)
    else $error("pslverr without pready");

  a_edge_rise: assert property (
    (opt_ff[OPT_SRC_BIT] && opt_ff[OPT_EDGE_BIT]
      && $rose(external_count_input)) |-> src_evt)
    else $error("rising pin edge missed");

  a_edge_fall: assert property (
    (opt_ff[OPT_SRC_BIT] && !opt_ff[OPT_EDGE_BIT]
      && $fell(external_count_input)) |-> src_evt)
    else $error("falling pin edge missed");

  a_timer_presc: assert property (
    (!prescaler_assign_bit && !(wr && hit_cnt) && pif.tick_out)
      |=> count_ff == $past(count_ff) + 8'h01)
    else $error("count missed a prescaler tick");

  a_presc_rate_one: assert property (
    (prescaler_assign_bit && wdt_ovf && pif.rate == 3'h1)
      |-> wdt_tmo == u_presc.cnt_ff[0])
    else $error("watchdog prescaler rate one wrong");

  a_expiry_enabled: assert property (
    wdt_reset |-> $past(wdt_en))
    else $error("expiry while watchdog disabled");

endmodule : twp_top

// ===== verif/twp_core_model.sv
`timescale 1ns/1ps
module twp_core_model
(
  // clock and handshake
  input  wire logic        clk_sys,
  input  wire logic        pready,
  // apb request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // every option write carries all fields at once
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    psel    <= 1'b0;
    penable <= 1'b0;
    // released lines flip so a stale value cannot pass for a fresh one
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask : xfer
endmodule : twp_core_model

// ===== verif/timer_watchdog_prescaler_bench.sv
`timescale 1ns/1ps
module timer_watchdog_prescaler_bench
  import twp_pkg::*;
;
  logic        clk_sys;
  logic        rst_b;
  logic        pin;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic        wdt_reset;
  logic        pd_flag;
  logic        to_flag;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] base;
  logic [34:0] exp_q[$];
  logic [34:0] e;
  int          err_count;
  int          check_count;
  int          wdt_exp;
  int          k;

  // short watchdog so an expiry fits in the run
  twp_top #(.WDT_W(4)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b),
    .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_count_input(pin), .wdt_reset(wdt_reset),
    .power_down_flag(pd_flag), .timeout_flag(to_flag));
  twp_core_model core_u (.clk_sys(clk_sys), .pready(pready), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic complete_run();
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  // d is write data, or the expected read data when w is low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic er);
    exp_q.push_back({!w && a == OFS_STATUS, ~w, er, d});
    core_u.xfer(w, a, w ? d : 32'h0);
  endtask : bus

  task automatic lvl(input logic v);
    @(posedge clk_sys);
    pin <= v;
    repeat (4) @(posedge clk_sys);
  endtask : lvl

  task automatic pulses(input int n);
    repeat (n)
    begin
      lvl(1'b1);
      lvl(1'b0);
    end
  endtask : pulses

  // answers are sampled mid-cycle, clear of the launching edge
  always @(negedge clk_sys)
  begin
    if (wdt_reset === 1'b1)
    begin
      if (wdt_exp > 0)
      begin
        wdt_exp--;
        check_count++;
      end
      else
      begin
        err_count++;
        $display("MISMATCH %0t watchdog reset unexpected", $time);
      end
    end
    if (pready === 1'b1 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      check_count++;
      if (pslverr !== e[32] || (e[33] && prdata !== e[31:0]))
      begin
        err_count++;
        $display("MISMATCH %0t answer %h exp %h", $time, prdata, e);
      end
      if (e[34] && (to_flag !== e[STAT_TO_BIT]
          || pd_flag !== e[STAT_PD_BIT]))
      begin
        err_count++;
        $display("MISMATCH %0t status pins %b %b", $time, to_flag, pd_flag);
      end
    end
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    complete_run();
  end

  initial
  begin
    rst_b = 1'b0;
    pin = 1'b0;
    err_count = 0;
    check_count = 0;
    wdt_exp = 0;
    base = $urandom(32'h96CF07C2);
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    bus(1'b0, OFS_STATUS, 32'h18, 1'b0);
    bus(1'b0, OFS_OPTION, 32'h0, 1'b0);
    bus(1'b0, 8'h10, 32'h0, 1'b1);
    bus(1'b1, 8'h14, 32'h5A, 1'b1);
    bus(1'b1, OFS_COUNT, 32'h0, 1'b0);
    pulses(3);
    bus(1'b0, OFS_COUNT, 32'h3, 1'b0);
    bus(1'b1, OFS_OPTION, 32'h28, 1'b0);
    lvl(1'b1);
    bus(1'b0, OFS_COUNT, 32'h3, 1'b0);
    lvl(1'b0);
    bus(1'b0, OFS_COUNT, 32'h4, 1'b0);
    bus(1'b1, OFS_CMD, 32'h1, 1'b0);
    bus(1'b1, OFS_OPTION, 32'h33, 1'b0);
    k = $urandom_range(3, 1);
    base = {24'h0, base[7:0]};
    bus(1'b1, OFS_COUNT, base, 1'b0);
    pulses(16 * k);
    bus(1'b0, OFS_COUNT, (base + k) & 32'hFF, 1'b0);
    pulses(8);
    bus(1'b1, OFS_CMD, 32'h1, 1'b0);
    pulses(8);
    bus(1'b0, OFS_COUNT, (base + k + 1) & 32'hFF, 1'b0);
    bus(1'b1, OFS_CMD, 32'h1, 1'b0);
    bus(1'b1, OFS_COUNT, 32'h0, 1'b0);
    bus(1'b1, OFS_OPTION, 32'h3F, 1'b0);
    bus(1'b1, OFS_CMD, 32'h1, 1'b0);
    bus(1'b1, OFS_OPTION, 32'h38, 1'b0);
    pulses(5);
    bus(1'b0, OFS_COUNT, 32'h5, 1'b0);
    bus(1'b1, OFS_OPTION, 32'h78, 1'b0);
    bus(1'b1, OFS_CMD, 32'h2, 1'b0);
    bus(1'b0, OFS_STATUS, 32'h10, 1'b0);
    bus(1'b1, OFS_CMD, 32'h1, 1'b0);
    bus(1'b0, OFS_STATUS, 32'h18, 1'b0);
    bus(1'b1, OFS_OPTION, 32'h79, 1'b0);
    bus(1'b1, OFS_CMD, 32'h2, 1'b0);
    repeat (480) @(posedge clk_sys);
    wdt_exp = 1;
    repeat (60) @(posedge clk_sys);
    if (wdt_exp != 0)
    begin
      err_count++;
      $display("MISMATCH %0t watchdog did not expire", $time);
    end
    bus(1'b0, OFS_STATUS, 32'h00, 1'b0);
    bus(1'b1, OFS_OPTION, 32'h38, 1'b0);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    bus(1'b0, OFS_STATUS, 32'h18, 1'b0);
    bus(1'b1, OFS_COUNT, 32'h0, 1'b0);
    pulses(2);
    bus(1'b0, OFS_COUNT, 32'h2, 1'b0);
    repeat (4) @(posedge clk_sys);
    complete_run();
  end
endmodule : timer_watchdog_prescaler_bench
